// [logic/scd_regs.svh]
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH
// ==================================================
// Command bytes
`define PREFIX_BYTE 8'hfe
`define FUNC_DISPLAY 8'h07
`define SUB_INIT 8'h00
`define SUB_DATA 8'h01
`define SUB_INSTR 8'h02
`define SUB_TEXT 8'h03
`define SUB_BL_OFF 8'h04
`define SUB_BL_ON 8'h05
`define SUB_PORT 8'h06
`define TERM_BYTE 8'hff
`define ACK_BYTE 8'h55
// ==================================================
// Display ports and pin positions
`define PORT_A 2'h0
`define PORT_B 2'h1
`define PORT_C 2'h2
`define NUM_PORTS 3
`define PIN_RS 0
`define PIN_RW 1
`define PIN_E 2
`define PIN_BL 3
`define PIN_D_LO 4
`define PIN_D_HI 7
// ==================================================
// Text buffer and init sequence
`define BUF_DEPTH 64
`define BUF_AW 6
`define INIT_LEN 3'h6
// ==================================================
// Timing
`define CLK_MHZ 40
`define NS_PER_US 1000
`define E_PULSE_NS 500
`define WRITE_WAIT_US 2000
`define WR_CNT_W 24
`define BAUD_DIV_RST 16'h0412
`define DATA_LAST 3'h7
`define FRAME_LAST 4'h9
// ==================================================
// Register map (word index in address bits 3:2)
`define REG_IDX 3:2
`define REG_BAUD 2'h0
`define REG_STATUS 2'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [logic/scd_pkg.sv]
`include "scd_regs.svh"
package scd_pkg;
  // ==================================================
  // Carriers
  typedef struct packed {logic [3:0] nib; logic rs; logic e;} lcd_bus_t;
  typedef struct packed {logic valid; logic [7:0] data;} byte_stream_t;
  typedef struct packed {
    logic [3:0] awaddr; logic awvalid; logic [31:0] wdata; logic [3:0] wstrb; logic wvalid;
    logic bready; logic [3:0] araddr; logic arvalid; logic rready;
  } axil_req_t;
  typedef struct packed {
    logic awready; logic wready; logic [1:0] bresp; logic bvalid;
    logic arready; logic [31:0] rdata; logic [1:0] rresp; logic rvalid;
  } axil_rsp_t;
  typedef struct packed {
    logic [16:0] zero_hi; logic [6:0] text_count; logic busy; logic [1:0] port_sel;
    logic [1:0] zero_mid; logic [2:0] backlight;
  } status_t;
  // ==================================================
  // States
  typedef enum logic [1:0] {L_IDLE, L_START, L_DATA, L_STOP} link_phase_t;
  typedef enum logic [1:0] {W_IDLE, W_SETUP, W_EHI, W_WAIT} wr_phase_t;
  typedef enum logic [3:0] {S_PREFIX, S_FUNC, S_SUB, S_PARAM, S_INIT, S_WRITE, S_TEXT, S_DUMP, S_ACK,
    S_DRAIN} cmd_state_t;
  typedef struct packed {
    link_phase_t rph; logic [15:0] rcnt; logic [2:0] rbit; logic [7:0] rsh; byte_stream_t rx;
    logic tbusy; logic [15:0] tcnt; logic [3:0] tbit; logic [9:0] tsh; logic line;
  } link_st_t;
  typedef struct packed {
    wr_phase_t ph; logic lo; logic [7:0] byte_v; logic [`WR_CNT_W-1:0] cnt; lcd_bus_t lcd;
  } wr_st_t;
  typedef struct packed {
    cmd_state_t fsm; logic [7:0] sub; logic [7:0] arg; logic [1:0] sel; logic [2:0] bl;
    logic [`BUF_DEPTH-1:0][7:0] text; logic [`BUF_AW:0] cnt; logic [`BUF_AW:0] idx;
    logic [2:0] init_idx; logic drain; logic issued; logic [`NUM_PORTS-1:0][7:0] pins;
    logic [15:0] div; logic aw_held; logic [3:0] awaddr; logic w_held; logic [31:0] wdata;
    logic [3:0] wstrb; logic bvalid; logic [1:0] bresp; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } cmd_st_t;
endpackage

// [logic/serial_byte_link.sv]
`timescale 1ns/1ps
`include "scd_regs.svh"
module serial_byte_link (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bit period in clock cycles
  input wire logic [15:0] div,
  // Serial pins
  input wire logic rx_line,
  output logic tx_line,
  // Byte side
  output scd_pkg::byte_stream_t rx,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  import scd_pkg::*;
  localparam link_st_t LINK_RST = '{rph: L_IDLE, line: 1'b1, default: '0};
  link_st_t st_ff;
  link_st_t nxt_st;

  // ==================================================
  // Receiver and transmitter; each bit counter is its own baud divider
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rx.valid = 1'b0;
    nxt_st.rcnt = (st_ff.rcnt == '0) ? st_ff.rcnt : st_ff.rcnt - 16'h1;
    nxt_st.tcnt = (st_ff.tcnt == '0) ? st_ff.tcnt : st_ff.tcnt - 16'h1;
    unique case (st_ff.rph)
      L_IDLE:
        if (!rx_line)
        begin
          nxt_st.rph = L_START;
          nxt_st.rcnt = {1'b0, div[15:1]}; // Sample at mid bit
        end
      L_START:
        if (st_ff.rcnt == '0)
        begin
          nxt_st.rph = rx_line ? L_IDLE : L_DATA; // Glitch, not a start bit
          nxt_st.rcnt = div - 16'h1;
          nxt_st.rbit = '0;
        end
      L_DATA:
        if (st_ff.rcnt == '0)
        begin
          nxt_st.rsh = {rx_line, st_ff.rsh[7:1]};
          nxt_st.rcnt = div - 16'h1;
          nxt_st.rbit = st_ff.rbit + 3'h1;
          if (st_ff.rbit == `DATA_LAST) nxt_st.rph = L_STOP;
        end
      L_STOP:
        if (st_ff.rcnt == '0)
        begin
          nxt_st.rph = L_IDLE;
          nxt_st.rx.valid = rx_line; // A framing error drops the byte
          nxt_st.rx.data = st_ff.rsh;
        end
    endcase
    if (!st_ff.tbusy && tx_valid)
    begin
      nxt_st.tbusy = 1'b1;
      nxt_st.tsh = {1'b1, tx_data, 1'b0};
      nxt_st.tcnt = div - 16'h1;
      nxt_st.tbit = '0;
      nxt_st.line = 1'b0;
    end
    else if (st_ff.tbusy && st_ff.tcnt == '0)
    begin
      nxt_st.tsh = {1'b1, st_ff.tsh[9:1]};
      nxt_st.tcnt = div - 16'h1;
      nxt_st.tbit = st_ff.tbit + 4'h1;
      nxt_st.line = st_ff.tsh[1];
      if (st_ff.tbit == `FRAME_LAST)
      begin
        nxt_st.tbusy = 1'b0;
        nxt_st.line = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn) st_ff <= LINK_RST;
    else st_ff <= nxt_st;
  end

  assign rx = st_ff.rx;
  assign tx_line = st_ff.line;
  assign tx_ready = !st_ff.tbusy;
endmodule // serial_byte_link

// [logic/lcd_nibble_writer.sv]
`timescale 1ns/1ps
`include "scd_regs.svh"
module lcd_nibble_writer #(
  parameter int E_CYC = 20,
  parameter int WAIT_CYC = 80000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Byte request
  input wire logic req_valid,
  input wire logic [7:0] req_byte,
  input wire logic req_rs,
  output logic req_ready,
  // Display side
  output scd_pkg::lcd_bus_t lcd
);
  import scd_pkg::*;
  localparam wr_st_t WR_RST = '{ph: W_IDLE, default: '0};
  localparam logic [`WR_CNT_W-1:0] E_LAST = `WR_CNT_W'(E_CYC - 1);
  localparam logic [`WR_CNT_W-1:0] W_LAST = `WR_CNT_W'(WAIT_CYC - 1);
  wr_st_t st_ff;
  wr_st_t nxt_st;

  // ==================================================
  // High nibble, low nibble, then a settle wait long enough for the slowest instruction
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.cnt = (st_ff.cnt == '0) ? st_ff.cnt : st_ff.cnt - `WR_CNT_W'(1);
    unique case (st_ff.ph)
      W_IDLE:
        if (req_valid)
        begin
          nxt_st.byte_v = req_byte;
          nxt_st.lcd.rs = req_rs;
          nxt_st.lcd.nib = req_byte[7:4];
          nxt_st.lo = 1'b0;
          nxt_st.cnt = E_LAST;
          nxt_st.ph = W_SETUP;
        end
      W_SETUP:
        if (st_ff.cnt == '0)
        begin
          nxt_st.lcd.e = 1'b1;
          nxt_st.cnt = E_LAST;
          nxt_st.ph = W_EHI;
        end
      W_EHI:
        if (st_ff.cnt == '0)
        begin
          nxt_st.lcd.e = 1'b0;
          nxt_st.lo = 1'b1;
          nxt_st.lcd.nib = st_ff.byte_v[3:0];
          nxt_st.cnt = st_ff.lo ? W_LAST : E_LAST;
          nxt_st.ph = st_ff.lo ? W_WAIT : W_SETUP;
        end
      W_WAIT:
        if (st_ff.cnt == '0) nxt_st.ph = W_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn) st_ff <= WR_RST;
    else st_ff <= nxt_st;
  end

  assign req_ready = (st_ff.ph == W_IDLE);
  assign lcd = st_ff.lcd;
endmodule // lcd_nibble_writer

// [logic/serial_char_display_cmd.sv]
`timescale 1ns/1ps
`include "scd_regs.svh"
// How it works
// - Commands start with byte 254, then group byte 7, sub-command, parameters.
// - Sub-command 0 sends a fixed init sequence leaving a blinking cursor home.
// - Sub-command 1 writes its parameter byte to the display as data.
// - Sub-command 2 writes its parameter byte unchanged as an instruction.
// - Init, data and instruction writes reply 85 when finished.
// - Sub-command 3 buffers text bytes until terminator 255, which is not stored.
// - The text buffer holds at most 64 characters.
// - A full buffer is written out at once; excess text bytes are dropped.
// - Buffered characters are paced; 85 follows the last one written.
// - Sub-command 4 switches the selected port's backlight off.
// - Backlights are off after reset.
// - Sub-command 5 switches the selected port's backlight on.
// - Backlight is data line 3 of the port, high means on.
// - Sub-command 6 with 0..2 routes later commands to port A, B or C.
// - Reset selects port C with three ports, port A with two.
// - Without port C, selecting value 2 is ignored.
// - Each port carries its own single display.
// - Displays are never read; the read/write line stays low.
// - Four-bit mode on seven lines; the eighth is backlight.
module serial_char_display_cmd #(
  parameter bit THREE_PORT = 1'b1,
  parameter int E_CYC = (`E_PULSE_NS * `CLK_MHZ + `NS_PER_US - 1) / `NS_PER_US,
  parameter int WAIT_CYC = `WRITE_WAIT_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire scd_pkg::axil_req_t axil_req,
  output scd_pkg::axil_rsp_t axil_rsp,
  // Serial link to the host
  input wire logic rx_line,
  output logic tx_line,
  // Display ports A, B, C
  output logic [7:0] port_a,
  output logic [7:0] port_b,
  output logic [7:0] port_c
);
  import scd_pkg::*;

  // ==================================================
  // Reset state
  localparam logic [1:0] SEL_RST = THREE_PORT ? `PORT_C : `PORT_A;
  localparam cmd_st_t CMD_RST = '{fsm: S_PREFIX, sel: SEL_RST, div: `BAUD_DIV_RST, default: '0};

  cmd_st_t st_ff;
  cmd_st_t nxt_st;
  byte_stream_t rx;
  lcd_bus_t lcd;
  logic tx_ready;
  logic tx_valid;
  logic wr_ready;
  logic wr_valid;
  logic wr_go;
  logic [7:0] wr_byte;
  logic wr_rs;
  status_t status;

  // ==================================================
  // Helpers
  // Fixed init: 8-bit wake, 4-bit switch, two lines, blinking cursor, clear, entry
  function automatic logic [7:0] init_byte(input logic [2:0] i);
    unique case (i)
      3'h0: init_byte = 8'h33;
      3'h1: init_byte = 8'h32;
      3'h2: init_byte = 8'h28;
      3'h3: init_byte = 8'h0f;
      3'h4: init_byte = 8'h01;
      default: init_byte = 8'h06;
    endcase
  endfunction

  function automatic logic port_ok(input logic [7:0] v);
    port_ok = (v == {6'h0, `PORT_A}) || (v == {6'h0, `PORT_B}) ||
      (v == {6'h0, `PORT_C} && THREE_PORT);
  endfunction

  function automatic logic is_term(input byte_stream_t b);
    is_term = b.valid && b.data == `TERM_BYTE;
  endfunction

  // ==================================================
  // Serial link and display writer
  serial_byte_link u_link (
    .aclk(aclk),
    .aresetn(aresetn),
    .div(st_ff.div),
    .rx_line(rx_line),
    .tx_line(tx_line),
    .rx(rx),
    .tx_valid(tx_valid),
    .tx_data(`ACK_BYTE),
    .tx_ready(tx_ready)
  );

  lcd_nibble_writer #(
    .E_CYC(E_CYC),
    .WAIT_CYC(WAIT_CYC)
  ) u_writer (
    .aclk(aclk),
    .aresetn(aresetn),
    .req_valid(wr_valid),
    .req_byte(wr_byte),
    .req_rs(wr_rs),
    .req_ready(wr_ready),
    .lcd(lcd)
  );

  // Writer request: one byte at a time, each paced by the writer's settle wait
  always_comb
  begin
    wr_valid = !st_ff.issued && (st_ff.fsm == S_INIT || st_ff.fsm == S_WRITE || st_ff.fsm == S_DUMP);
    wr_go = wr_valid && wr_ready;
    wr_rs = (st_ff.fsm == S_DUMP) || (st_ff.fsm == S_WRITE && st_ff.sub == `SUB_DATA);
    unique case (st_ff.fsm)
      S_INIT: wr_byte = init_byte(st_ff.init_idx);
      S_DUMP: wr_byte = st_ff.text[st_ff.idx[`BUF_AW-1:0]];
      default: wr_byte = st_ff.arg; // Passed on unmodified
    endcase
  end

  // Reply byte only leaves from the acknowledge state
  assign tx_valid = (st_ff.fsm == S_ACK);

  // Status word seen by software
  always_comb
  begin
    status = '0;
    status.text_count = st_ff.cnt;
    status.busy = (st_ff.fsm != S_PREFIX);
    status.port_sel = st_ff.sel;
    status.backlight = st_ff.bl;
  end

  // ==================================================
  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    // Command parser; bytes in write and reply states are ignored
    unique case (st_ff.fsm)
      S_PREFIX:
        if (rx.valid && rx.data == `PREFIX_BYTE) nxt_st.fsm = S_FUNC;
      S_FUNC:
        if (rx.valid) nxt_st.fsm = (rx.data == `FUNC_DISPLAY) ? S_SUB : S_PREFIX;
      S_SUB:
        if (rx.valid)
        begin
          nxt_st.sub = rx.data;
          nxt_st.fsm = S_PREFIX;
          case (rx.data)
            `SUB_INIT:
            begin
              nxt_st.fsm = S_INIT;
              nxt_st.init_idx = '0;
            end
            `SUB_DATA, `SUB_INSTR, `SUB_PORT: nxt_st.fsm = S_PARAM;
            `SUB_TEXT:
            begin
              nxt_st.fsm = S_TEXT;
              nxt_st.cnt = '0;
              nxt_st.drain = 1'b0;
            end
            `SUB_BL_OFF: nxt_st.bl[st_ff.sel] = 1'b0; // No reply
            `SUB_BL_ON: nxt_st.bl[st_ff.sel] = 1'b1; // No reply
            default: nxt_st.fsm = S_PREFIX; // Unsupported sub-commands are dropped
          endcase
        end
      S_PARAM:
        if (rx.valid)
        begin
          nxt_st.arg = rx.data;
          nxt_st.fsm = S_WRITE;
          if (st_ff.sub == `SUB_PORT)
          begin
            nxt_st.fsm = S_PREFIX; // No reply
            if (port_ok(rx.data)) nxt_st.sel = rx.data[1:0];
          end
        end
      S_INIT:
        if (wr_go)
        begin
          nxt_st.init_idx = st_ff.init_idx + 3'h1;
          nxt_st.issued = (st_ff.init_idx == `INIT_LEN - 3'h1);
        end
      S_WRITE:
        if (wr_go) nxt_st.issued = 1'b1;
      S_TEXT:
        if (is_term(rx))
        begin
          nxt_st.fsm = S_DUMP; // Terminator is not stored
          nxt_st.idx = '0;
          nxt_st.issued = (st_ff.cnt == '0);
        end
        else if (rx.valid)
        begin
          nxt_st.text[st_ff.cnt[`BUF_AW-1:0]] = rx.data;
          nxt_st.cnt = st_ff.cnt + 7'h1;
          if (st_ff.cnt == 7'(`BUF_DEPTH - 1))
          begin
            nxt_st.fsm = S_DUMP; // Full: show now, drop the rest
            nxt_st.idx = '0;
            nxt_st.drain = 1'b1;
          end
        end
      S_DUMP:
        if (wr_go)
        begin
          nxt_st.idx = st_ff.idx + 7'h1;
          nxt_st.issued = (st_ff.idx + 7'h1 == st_ff.cnt);
        end
      S_ACK:
        if (tx_ready) nxt_st.fsm = st_ff.drain ? S_DRAIN : S_PREFIX;
      S_DRAIN:
        if (!st_ff.drain) nxt_st.fsm = S_PREFIX;
    endcase
    // Excess text after a full buffer is swallowed up to its terminator
    if (st_ff.drain && is_term(rx)) nxt_st.drain = 1'b0;
    // Last byte accepted and writer idle again: the display has finished
    if (st_ff.issued && wr_ready)
    begin
      nxt_st.issued = 1'b0;
      nxt_st.fsm = S_ACK;
    end

    // Port pins, one display per port; read/write line is always low
    for (int p = 0; p < `NUM_PORTS; p++)
    begin
      nxt_st.pins[p] = '0;
      nxt_st.pins[p][`PIN_BL] = st_ff.bl[p];
      if (st_ff.sel == 2'(p))
      begin
        nxt_st.pins[p][`PIN_RS] = lcd.rs;
        nxt_st.pins[p][`PIN_E] = lcd.e;
        nxt_st.pins[p][`PIN_D_HI:`PIN_D_LO] = lcd.nib;
      end
    end
    if (!THREE_PORT) nxt_st.pins[`PORT_C] = '0; // No port C

    // Register bus: address and data taken in either order
    if (axil_req.awvalid && axil_rsp.awready)
    begin
      nxt_st.aw_held = 1'b1;
      nxt_st.awaddr = axil_req.awaddr;
    end
    if (axil_req.wvalid && axil_rsp.wready)
    begin
      nxt_st.w_held = 1'b1;
      nxt_st.wdata = axil_req.wdata;
      nxt_st.wstrb = axil_req.wstrb;
    end
    if (st_ff.bvalid && axil_req.bready) nxt_st.bvalid = 1'b0;
    if (st_ff.aw_held && st_ff.w_held)
    begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = `RESP_OKAY;
      if (st_ff.awaddr[`REG_IDX] == `REG_BAUD)
      begin
        if (st_ff.wstrb[0]) nxt_st.div[7:0] = st_ff.wdata[7:0];
        if (st_ff.wstrb[1]) nxt_st.div[15:8] = st_ff.wdata[15:8];
      end
      else if (st_ff.awaddr[`REG_IDX] != `REG_STATUS) nxt_st.bresp = `RESP_SLVERR;
    end

    // Register bus: reads answer one cycle after the address is taken
    if (st_ff.rvalid && axil_req.rready) nxt_st.rvalid = 1'b0;
    if (axil_req.arvalid && axil_rsp.arready)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `RESP_OKAY;
      nxt_st.rdata = '0;
      case (axil_req.araddr[`REG_IDX])
        `REG_BAUD: nxt_st.rdata = {16'h0, st_ff.div};
        `REG_STATUS: nxt_st.rdata = status;
        default: nxt_st.rresp = `RESP_SLVERR;
      endcase
    end
  end

  // ==================================================
  // State register; backlights clear and port selection defaults here
  always_ff @(posedge aclk)
  begin
    if (!aresetn) st_ff <= CMD_RST;
    else st_ff <= nxt_st;
  end

  // ==================================================
  // Outputs
  always_comb
  begin
    axil_rsp.awready = !st_ff.aw_held && !st_ff.bvalid;
    axil_rsp.wready = !st_ff.w_held && !st_ff.bvalid;
    axil_rsp.bresp = st_ff.bresp;
    axil_rsp.bvalid = st_ff.bvalid;
    axil_rsp.arready = !st_ff.rvalid;
    axil_rsp.rdata = st_ff.rdata;
    axil_rsp.rresp = st_ff.rresp;
    axil_rsp.rvalid = st_ff.rvalid;
  end

  assign port_a = st_ff.pins[`PORT_A];
  assign port_b = st_ff.pins[`PORT_B];
  assign port_c = st_ff.pins[`PORT_C];
endmodule // serial_char_display_cmd

// [verif/scd_cmd_checker.sv]
`timescale 1ns/1ps
// ==================================================
// Port checker for the display command decoder
module scd_cmd_checker
  import scd_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire scd_pkg::axil_req_t axil_req,
  input wire scd_pkg::axil_rsp_t axil_rsp,
  // Serial and display pins
  input wire logic rx_line,
  input wire logic tx_line,
  input wire logic [7:0] port_a,
  input wire logic [7:0] port_b,
  input wire logic [7:0] port_c
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==================================================
  // Display pins
  a_never_read: assert property (!port_a[1] && !port_b[1] && !port_c[1])
    else $error("display read line raised");
  a_dark_reset: assert property ($rose(aresetn) |-> !port_a[3] && !port_b[3] && !port_c[3] && tx_line)
    else $error("backlight or serial line wrong after reset");
  a_one_strobe: assert property ($onehot0({port_a[2], port_b[2], port_c[2]}))
    else $error("two ports strobed together");
  // Port C nibble and register select must not move while port C's strobe is high
  a_nibble_steady: assert property (port_c[2] && $past(port_c[2]) |-> $stable({port_c[7:4], port_c[0]}))
    else $error("nibble changed under strobe");
  // ==================================================
  // Register bus
  a_read_latency: assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
    else $error("read answer late");
  a_write_latency: assert property (axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready
    |=> ##1 axil_rsp.bvalid)
    else $error("write answer late");
  a_write_refuse: assert property (axil_rsp.bvalid |-> !axil_rsp.awready && !axil_rsp.wready)
    else $error("write taken while answer pending");
  a_read_refuse: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
    else $error("read taken while answer pending");
  // Main scenarios reached
  c_write: cover property (axil_rsp.bvalid);
  c_text_port: cover property ($rose(port_b[2]));
  c_reply: cover property ($fell(tx_line));
endmodule // scd_cmd_checker

bind serial_char_display_cmd scd_cmd_checker i_chk (.aclk(aclk), .aresetn(aresetn), .axil_req(axil_req),
  .axil_rsp(axil_rsp), .rx_line(rx_line), .tx_line(tx_line), .port_a(port_a), .port_b(port_b), .port_c(port_c));

// [verif/host_serial_model.sv]
`timescale 1ns/1ps
// ==================================================
// Host end of the serial link, 8N1, LSB first
module host_serial_model #(
  parameter int BIT = 16
) (
  // Clock
  input wire logic aclk,
  // Serial pins
  output logic rx_line,
  input wire logic tx_line
);
  // Line idles high between frames
  initial rx_line = 1'b1;
  // One frame, each bit held BIT cycles
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge aclk);
      rx_line <= f[i];
      repeat (BIT - 1) @(posedge aclk);
    end
  endtask
  // Bit 8 is the stop bit, so a missing reply reads all zero
  task automatic get_byte(input int limit, output logic [8:0] r);
    int n;
    r = 9'h000;
    n = 0;
    while (tx_line !== 1'b0 && n < limit)
    begin
      @(posedge aclk);
      n++;
    end
    if (n < limit)
    begin
      for (int i = 0; i < 9; i++)
      begin
        repeat (i == 0 ? BIT + BIT / 2 : BIT) @(posedge aclk);
        r[i] = tx_line;
      end
    end
  endtask
endmodule // host_serial_model

// [verif/serial_char_display_cmd_test.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module serial_char_display_cmd_test;
  import scd_pkg::*;
  logic aclk, aresetn, rx_line, tx_line;
  axil_req_t req;
  axil_rsp_t rsp;
  logic [7:0] pins [3];
  logic [2:0] e_q;
  logic [4:0] seen [3][$];
  int n_mismatch, n_compared;
  // ==================================================
  // Device and host; short strobe and settle keep the run brief
  serial_char_display_cmd #(.E_CYC(2), .WAIT_CYC(40)) i_dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req),
    .axil_rsp(rsp), .rx_line(rx_line), .tx_line(tx_line), .port_a(pins[0]), .port_b(pins[1]), .port_c(pins[2]));
  host_serial_model #(.BIT(16)) i_host (.aclk(aclk), .rx_line(rx_line), .tx_line(tx_line));
  // 40 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Record register select and nibble at every strobe rise
  always @(posedge aclk)
  begin
    for (int p = 0; p < 3; p++)
    begin
      if (pins[p][2] === 1'b1 && e_q[p] !== 1'b1) seen[p].push_back({pins[p][0], pins[p][7:4]});
      e_q[p] <= pins[p][2];
    end
  end
  // ==================================================
  // Helpers
  // Handshakes are judged mid-cycle, where the values that the next edge samples have settled
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_hs, w_hs, b_hs;
    n = 0;
    b_hs = 1'b0;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (b_hs !== 1'b1 && n < 200)
    begin
      @(negedge aclk);
      aw_hs = req.awvalid && rsp.awready;
      w_hs = req.wvalid && rsp.wready;
      b_hs = rsp.bvalid;
      r = rsp.bresp;
      @(posedge aclk);
      n++;
      if (aw_hs) req.awvalid <= 1'b0;
      if (w_hs) req.wvalid <= 1'b0;
    end
    if (b_hs !== 1'b1) n_mismatch++;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_hs, r_hs;
    n = 0;
    r_hs = 1'b0;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    while (r_hs !== 1'b1 && n < 200)
    begin
      @(negedge aclk);
      ar_hs = req.arvalid && rsp.arready;
      r_hs = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge aclk);
      n++;
      if (ar_hs) req.arvalid <= 1'b0;
    end
    if (r_hs !== 1'b1) n_mismatch++;
  endtask
  task automatic send_seq(input logic [7:0] q[$]);
    foreach (q[i]) i_host.send_byte(q[i]);
  endtask
  task automatic reply(input logic [8:0] e, input int lim);
    logic [8:0] r;
    i_host.get_byte(lim, r);
    `CHK(r, e)
  endtask
  task automatic nib(input int p, input logic [7:0] b, input logic rs);
    logic [4:0] hi, lo;
    hi = seen[p].pop_front();
    lo = seen[p].pop_front();
    `CHK({hi, lo}, {rs, b[7:4], rs, b[3:0]})
  endtask
  task automatic clear();
    foreach (seen[p]) seen[p].delete();
  endtask
  // ==================================================
  // Scenarios
  task automatic t_registers();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(4'h0, d, r);
    `CHK({r, d}, {2'h0, 32'h0000_0412})
    axi_rd(4'h4, d, r);
    `CHK(d, 32'h0000_0040)
    axi_wr(4'h4, 32'hffff_ffff, r);
    `CHK(r, 2'h0)
    axi_rd(4'h8, d, r);
    `CHK({r, d}, {2'h2, 32'h0})
    axi_wr(4'hc, 32'h1, r);
    `CHK(r, 2'h2)
    // Faster bit time so frames stay short
    axi_wr(4'h0, 32'h0000_0010, r);
    axi_rd(4'h0, d, r);
    `CHK(d, 32'h0000_0010)
  endtask
  task automatic t_writes();
    for (int i = 0; i < 2; i++)
    begin
      clear();
      send_seq('{8'hfe, 8'h07, (i == 0) ? 8'h01 : 8'h02, (i == 0) ? 8'h41 : 8'h8c});
      reply(9'h155, 2000);
      nib(2, (i == 0) ? 8'h41 : 8'h8c, i == 0);
    end
  endtask
  task automatic t_routing();
    send_seq('{8'hfe, 8'h08, 8'h01, 8'h41});
    reply(9'h000, 300);
    send_seq('{8'hfe, 8'h07, 8'h05});
    reply(9'h000, 300);
    `CHK(pins[2][3], 1'b1)
    send_seq('{8'hfe, 8'h07, 8'h06, 8'h00});
    send_seq('{8'hfe, 8'h07, 8'h05});
    `CHK(pins[0][3], 1'b1)
    send_seq('{8'hfe, 8'h07, 8'h04});
    reply(9'h000, 300);
    `CHK({pins[0][3], pins[2][3]}, 2'h1)
    send_seq('{8'hfe, 8'h07, 8'h06, 8'h03});
    clear();
    send_seq('{8'hfe, 8'h07, 8'h01, 8'h5a});
    reply(9'h155, 2000);
    nib(0, 8'h5a, 1'b1);
    `CHK(seen[1].size() + seen[2].size(), 0)
    send_seq('{8'hfe, 8'h07, 8'h06, 8'h01});
  endtask
  task automatic t_init();
    logic [7:0] s [6] = '{8'h33, 8'h32, 8'h28, 8'h0f, 8'h01, 8'h06};
    clear();
    send_seq('{8'hfe, 8'h07, 8'h00});
    reply(9'h155, 3000);
    foreach (s[i]) nib(1, s[i], 1'b0);
  endtask
  task automatic t_text();
    clear();
    send_seq('{8'hfe, 8'h07, 8'h03, 8'h48, 8'h69, 8'hff});
    reply(9'h155, 2000);
    nib(1, 8'h48, 1'b1);
    nib(1, 8'h69, 1'b1);
    `CHK(seen[1].size(), 0)
    // Overflow: the 64th byte starts the dump while the host keeps sending
    send_seq('{8'hfe, 8'h07, 8'h03});
    for (int i = 0; i < 64; i++) i_host.send_byte(8'h30 + 8'(i));
    fork
      send_seq('{8'h21, 8'h22, 8'hff});
      reply(9'h155, 20000);
    join
    `CHK(seen[1].size(), 128)
    `CHK(seen[1][127], 5'h1f)
  endtask
  // ==================================================
  // Verdict, watchdog and main sequence
  task automatic give_verdict();
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge aclk);
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    aresetn = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    @(posedge aclk);
    `CHK({tx_line, pins[0][3], pins[1][3], pins[2][3]}, 4'h8)
    t_registers();
    t_writes();
    t_routing();
    t_init();
    t_text();
    give_verdict();
  end
endmodule // serial_char_display_cmd_test
